// File: bench/vector_pipeline_chaining_tb_top.sv
`default_nettype none
`define CHK(a, b) \
	begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("Error %0t %h %h", $time, (a), (b)); end end
module vector_pipeline_chaining_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] W = 64'h1000_0000_0000_0001;
	localparam logic [63:0] S = 64'hFFFF_0000_F0F0_FFFF;
	int mismatches = 0;
	int check_count = 0;
	logic clk_i, reset_i, inst_valid_i, inst_ready_o, inst_use_scalar_i;
	vpc_pkg::vpc_op_t inst_op_i;
	logic [2:0] inst_dst_i, first_operand_array_i, second_operand_array_i;
	logic [63:0] inst_scalar_i, element_mask_register_o;
	logic [63:0] mem_rd_data_i, mem_wr_data_o;
	logic [6:0] element_count_register_o;
	logic [2:0] unit_busy_o;
	logic [7:0] reg_reserved_o;
	logic mem_rd_valid_i, mem_rd_ready_o, mem_wr_valid_o, mem_wr_ready_i;
	vpc_chain_ctrl u_dut (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.inst_valid_i(inst_valid_i),
		.inst_ready_o(inst_ready_o),
		.inst_op_i(inst_op_i),
		.inst_dst_i(inst_dst_i),
		.first_operand_array_i(first_operand_array_i),
		.second_operand_array_i(second_operand_array_i),
		.inst_scalar_i(inst_scalar_i),
		.inst_use_scalar_i(inst_use_scalar_i),
		.element_count_register_o(element_count_register_o),
		.element_mask_register_o(element_mask_register_o),
		.unit_busy_o(unit_busy_o),
		.reg_reserved_o(reg_reserved_o),
		.mem_rd_valid_i(mem_rd_valid_i),
		.mem_rd_data_i(mem_rd_data_i),
		.mem_rd_ready_o(mem_rd_ready_o),
		.mem_wr_valid_o(mem_wr_valid_o),
		.mem_wr_data_o(mem_wr_data_o),
		.mem_wr_ready_i(mem_wr_ready_i)
	);
	vpc_mem_model u_mem (.clk_i(clk_i), .reset_i(reset_i),
		.rd_ready_i(mem_rd_ready_o), .rd_valid_o(mem_rd_valid_i),
		.rd_data_o(mem_rd_data_i), .wr_valid_i(mem_wr_valid_o),
		.wr_data_i(mem_wr_data_o), .wr_ready_o(mem_wr_ready_i));
	always #4 clk_i = ~clk_i;
	task automatic wrap_up();
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	// leaves valid up so back-to-back issues never drive it twice
	task automatic issue(input vpc_pkg::vpc_op_t op, input logic [2:0] d,
		input logic [2:0] a, input logic [2:0] b, input logic us);
		int n;
		n = 0;
		inst_op_i = op;
		inst_dst_i = d;
		first_operand_array_i = a;
		second_operand_array_i = b;
		inst_use_scalar_i = us;
		inst_valid_i = 1'b1;
		@(negedge clk_i);
		while (inst_ready_o !== 1'b1 && n < 900)
		begin
			n++;
			@(negedge clk_i);
		end
		`CHK(inst_ready_o, 1'b1)
		@(posedge clk_i);
		#1;
	endtask : issue
	task automatic t_reset();
		`CHK(element_count_register_o, 7'h40)
		`CHK(element_mask_register_o, 64'h0)
		`CHK(unit_busy_o, 3'h0)
	endtask : t_reset
	task automatic t_regs();
		inst_scalar_i = 64'h64;
		issue(vpc_pkg::OP_SET_VL, 3'h0, 3'h0, 3'h0, 1'b0);
		inst_valid_i = 1'b0;
		@(posedge clk_i);
		#1;
		`CHK(element_count_register_o, 7'h40)
		inst_scalar_i = 64'h3;
		issue(vpc_pkg::OP_SET_VL, 3'h0, 3'h0, 3'h0, 1'b0);
		inst_scalar_i = 64'hA000_0000_0000_0000;
		issue(vpc_pkg::OP_SET_VM, 3'h0, 3'h0, 3'h0, 1'b0);
		inst_valid_i = 1'b0;
		@(posedge clk_i);
		#1;
		`CHK(element_count_register_o, 7'h03)
		`CHK(element_mask_register_o, 64'hA000_0000_0000_0000)
	endtask : t_regs
	// two loads, chained add, scalar and, merge, two stores
	task automatic t_chain();
		logic [63:0] sum;
		int n;
		n = 0;
		inst_scalar_i = S;
		issue(vpc_pkg::OP_LOAD, 3'h1, 3'h1, 3'h1, 1'b0);
		issue(vpc_pkg::OP_LOAD, 3'h0, 3'h0, 3'h0, 1'b0);
		issue(vpc_pkg::OP_ADD, 3'h2, 3'h0, 3'h1, 1'b0);
		issue(vpc_pkg::OP_AND, 3'h3, 3'h2, 3'h0, 1'b1);
		issue(vpc_pkg::OP_MERGE, 3'h4, 3'h2, 3'h0, 1'b1);
		issue(vpc_pkg::OP_STORE, 3'h3, 3'h3, 3'h3, 1'b0);
		issue(vpc_pkg::OP_STORE, 3'h4, 3'h4, 3'h4, 1'b0);
		inst_valid_i = 1'b0;
		while ((u_mem.wr_q.size() < 6 || unit_busy_o !== 3'h0) && n < 2000)
		begin
			n++;
			@(posedge clk_i);
		end
		#1;
		`CHK(u_mem.wr_q.size(), 6)
		`CHK(reg_reserved_o, 8'h0)
		for (int i = 0; i < 3; i++)
		begin
			sum = W * 64'(2 * i + 5);
			`CHK(u_mem.wr_q[i], sum & S)
			`CHK(u_mem.wr_q[i + 3], (i == 1) ? S : sum)
		end
	endtask : t_chain
	// subtract on the add unit, chained into a store
	task automatic t_sub();
		int n;
		n = 0;
		issue(vpc_pkg::OP_SUB, 3'h5, 3'h2, 3'h0, 1'b0);
		issue(vpc_pkg::OP_STORE, 3'h5, 3'h5, 3'h5, 1'b0);
		inst_valid_i = 1'b0;
		while ((u_mem.wr_q.size() < 9 || unit_busy_o !== 3'h0) && n < 900)
		begin
			n++;
			@(posedge clk_i);
		end
		#1;
		`CHK(u_mem.wr_q.size(), 9)
		`CHK(reg_reserved_o, 8'h0)
		for (int i = 0; i < 3; i++)
			`CHK(u_mem.wr_q[i + 6], W * 64'(i + 1))
	endtask : t_sub
	initial
	begin
		#100000;
		mismatches++;
		wrap_up();
	end
	initial
	begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		inst_valid_i = 1'b0;
		inst_op_i = vpc_pkg::OP_ADD;
		inst_dst_i = 3'h0;
		first_operand_array_i = 3'h0;
		second_operand_array_i = 3'h0;
		inst_scalar_i = 64'h0;
		inst_use_scalar_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		t_reset();
		t_regs();
		t_chain();
		t_sub();
		wrap_up();
	end
endmodule : vector_pipeline_chaining_tb_top
`default_nettype wire

// File: bench/vpc_chain_props.sv
`default_nettype none
module vpc_chain_props #(
	parameter int NREG = 8,
	parameter int RW = 3
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic inst_valid_i,
	input wire logic inst_ready_o,
	input wire vpc_pkg::vpc_op_t inst_op_i,
	input wire logic [RW-1:0] inst_dst_i,
	input wire logic [63:0] inst_scalar_i,
	input wire logic [6:0] element_count_register_o,
	input wire logic [63:0] element_mask_register_o,
	input wire logic [2:0] unit_busy_o,
	input wire logic [NREG-1:0] reg_reserved_o,
	input wire logic mem_rd_ready_o,
	input wire logic mem_wr_valid_o,
	input wire logic [63:0] mem_wr_data_o,
	input wire logic mem_wr_ready_i
);
	logic acc;
	logic is_add;
	logic add_acc;
	logic [6:0] sc_lo;
	logic [RW-1:0] dst_q;
	assign acc = inst_valid_i & inst_ready_o;
	assign is_add = inst_op_i == vpc_pkg::OP_ADD
		|| inst_op_i == vpc_pkg::OP_SUB;
	assign add_acc = acc && is_add && element_count_register_o != 7'h0;
	assign sc_lo = inst_scalar_i[6:0];
	always_ff @(posedge clk_i)
		dst_q <= inst_dst_i;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	reset_vals_a: assert property ($fell(reset_i) |->
		element_count_register_o == 7'h40 && unit_busy_o == 3'h0
		&& element_mask_register_o == 64'h0) else $error("bad reset state");
	count_set_a: assert property (
		acc && inst_op_i == vpc_pkg::OP_SET_VL && inst_scalar_i <= 64'h40
		|=> element_count_register_o == $past(sc_lo)) else $error("bad count");
	mask_set_a: assert property (
		acc && inst_op_i == vpc_pkg::OP_SET_VM
		|=> element_mask_register_o == $past(inst_scalar_i))
		else $error("bad mask");
	add_lat_a: assert property (add_acc |=> unit_busy_o[0] [*7])
		else $error("add unit freed too early");
	dst_resv_a: assert property (add_acc |=> reg_reserved_o[dst_q])
		else $error("destination not reserved");
	unit_hold_a: assert property (
		inst_valid_i && is_add && unit_busy_o[0] |-> !inst_ready_o)
		else $error("issued to busy unit");
	rd_idle_a: assert property (!unit_busy_o[2] |-> !mem_rd_ready_o)
		else $error("load word taken while path idle");
	wr_hold_a: assert property (
		mem_wr_valid_o && !mem_wr_ready_i
		|=> mem_wr_valid_o && $stable(mem_wr_data_o))
		else $error("store word lost in stall");
endmodule : vpc_chain_props
bind vpc_chain_ctrl vpc_chain_props #(.NREG(NREG), .RW(RW)) u_props (
	.clk_i(clk_i), .reset_i(reset_i), .inst_valid_i(inst_valid_i),
	.inst_ready_o(inst_ready_o), .inst_op_i(inst_op_i),
	.inst_dst_i(inst_dst_i), .inst_scalar_i(inst_scalar_i),
	.element_count_register_o(element_count_register_o),
	.element_mask_register_o(element_mask_register_o),
	.unit_busy_o(unit_busy_o), .reg_reserved_o(reg_reserved_o),
	.mem_rd_ready_o(mem_rd_ready_o), .mem_wr_valid_o(mem_wr_valid_o),
	.mem_wr_data_o(mem_wr_data_o), .mem_wr_ready_i(mem_wr_ready_i));
`default_nettype wire

// File: bench/vpc_mem_model.sv
`default_nettype none
module vpc_mem_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic rd_ready_i,
	output logic rd_valid_o,
	output logic [63:0] rd_data_o,
	input wire logic wr_valid_i,
	input wire logic [63:0] wr_data_i,
	output logic wr_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] WORD = 64'h1000_0000_0000_0001;
	logic [7:0] cyc_q;
	logic [63:0] idx_q;
	logic [63:0] wr_q[$];
	always @(posedge clk_i)
	begin
		cyc_q <= reset_i ? 8'h0 : cyc_q + 8'h1;
		if (reset_i)
		begin
			rd_valid_o <= 1'b0;
			idx_q <= 64'h0;
		end
		else
		begin
			if (rd_valid_o && rd_ready_i)
				idx_q <= idx_q + 64'h1;
			if (!rd_valid_o || rd_ready_i)
				rd_valid_o <= cyc_q[1:0] != 2'h1;
			if (wr_valid_i && wr_ready_o)
				wr_q.push_back(wr_data_i);
		end
	end
	// idle data inverted so a stale word never looks valid
	assign rd_data_o = rd_valid_o ? WORD * (idx_q + 64'h1) : ~(WORD * idx_q);
	// store side stalls half the time
	assign wr_ready_o = cyc_q[2];
endmodule : vpc_mem_model
`default_nettype wire

// File: pkg/vpc_pkg.sv
// Overview of operation
// - each unit segment passes its partial result on while taking a new pair
// - after the first result, later results arrive one per clock while operand elements keep pace
// - functional units run independently, so different instructions overlap
// - every element and scalar operand is a single 64-bit word
// - an instruction stops once completed elements equal the element count
// - successive elements feed the unit; results fill successive elements
// - a reserved destination may be read as a source by later instructions
// - consumers of a stalled load proceed as each element arrives
// - full chaining: consumer takes element 0 in its arrival period
// - a consumer issued after element 0 arrived still chains partially
// - chaining may begin at any element position of the result stream
// - each functional unit has a fixed latency of its own
// - vector-scalar operations pair the scalar copy with every element
// - the memory path is reserved and timed like a functional unit
// - vector-vector ops read one or two sources, write a distinct target
// - memory instructions load a vector register or store one
// - a separate class writes the mask and writes or reads the count; the code has only OP_SET_VL and OP_SET_VM, no count read
// - mask msb belongs to element 0, lsb to element 63
`default_nettype none
package vpc_pkg;
	localparam int ELEM_W = 64;
	localparam int MAX_VL = 64;
	localparam int CNT_W = 7;
	localparam int IDX_W = 6;
	localparam int NUM_UNITS = 3;
	localparam int UNIT_ADD = 0;
	localparam int UNIT_LOGIC = 1;
	localparam int UNIT_MEM = 2;
	localparam int ADD_LAT = 6;
	localparam int LOGIC_LAT = 2;
	localparam int BUF_DEPTH = 2;
	localparam logic [CNT_W-1:0] VL_RESET = 7'h40;
	localparam logic [CNT_W-1:0] VL_MAX = 7'h40;
	localparam logic [ELEM_W-1:0] VM_RESET = 64'h0;

	typedef enum logic [3:0] {
		OP_ADD, OP_SUB, OP_AND, OP_MERGE,
		OP_LOAD, OP_STORE, OP_SET_VL, OP_SET_VM
	} vpc_op_t;

	typedef enum logic [1:0] {FN_ADD, FN_SUB, FN_AND, FN_PASS} vpc_fn_t;

	function automatic int unit_of(input vpc_op_t op);
		if (op == OP_ADD || op == OP_SUB)
			return UNIT_ADD;
		if (op == OP_AND || op == OP_MERGE)
			return UNIT_LOGIC;
		return UNIT_MEM;
	endfunction : unit_of

	function automatic vpc_fn_t fn_of(input vpc_op_t op);
		if (op == OP_ADD)
			return FN_ADD;
		if (op == OP_SUB)
			return FN_SUB;
		if (op == OP_AND)
			return FN_AND;
		return FN_PASS;
	endfunction : fn_of
endpackage : vpc_pkg
`default_nettype wire

// File: verilog/vpc_chain_ctrl.sv
`default_nettype none
module vpc_chain_ctrl #(
	parameter int NREG = 8,
	parameter int RW = $clog2(NREG)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// instruction issue
	input wire logic inst_valid_i,
	output logic inst_ready_o,
	input wire vpc_pkg::vpc_op_t inst_op_i,
	input wire logic [RW-1:0] inst_dst_i,
	input wire logic [RW-1:0] first_operand_array_i,
	input wire logic [RW-1:0] second_operand_array_i,
	input wire logic [vpc_pkg::ELEM_W-1:0] inst_scalar_i,
	input wire logic inst_use_scalar_i,
	// state seen by issue logic
	output logic [vpc_pkg::CNT_W-1:0] element_count_register_o,
	output logic [vpc_pkg::ELEM_W-1:0] element_mask_register_o,
	output logic [vpc_pkg::NUM_UNITS-1:0] unit_busy_o,
	output logic [NREG-1:0] reg_reserved_o,
	// load data from memory
	input wire logic mem_rd_valid_i,
	input wire logic [vpc_pkg::ELEM_W-1:0] mem_rd_data_i,
	output logic mem_rd_ready_o,
	// store data to memory
	output logic mem_wr_valid_o,
	output logic [vpc_pkg::ELEM_W-1:0] mem_wr_data_o,
	input wire logic mem_wr_ready_i
);
	localparam int NU = vpc_pkg::NUM_UNITS;
	localparam int CW = vpc_pkg::CNT_W;
	localparam int EW = vpc_pkg::ELEM_W;

	if (NREG < 3 || RW != $clog2(NREG))
		$error("register count unsupported");

	logic [EW-1:0] vreg_q [NREG][vpc_pkg::MAX_VL];
	logic [NREG-1:0] busy_q;
	logic [CW-1:0] wcnt_q [NREG];
	logic [CW-1:0] vl_q;
	logic [EW-1:0] vm_q;

	logic [NU-1:0] act_q;
	vpc_pkg::vpc_op_t op_q [NU];
	logic [RW-1:0] dst_q [NU];
	logic [RW-1:0] s1_q [NU];
	logic [RW-1:0] s2_q [NU];
	logic [EW-1:0] sc_q [NU];
	logic [NU-1:0] usc_q;
	logic [CW-1:0] len_q [NU];
	logic [CW-1:0] ie_q [NU];
	logic [CW-1:0] re_q [NU];

	logic [NU-1:0] wr_v;
	logic [RW-1:0] wr_r [NU];
	logic [CW-1:0] wr_i [NU];
	logic [EW-1:0] wr_d [NU];
	logic [NU-1:0] fire;
	logic [EW-1:0] opa [NU];
	logic [EW-1:0] opb [NU];
	logic [1:0] so_v;
	logic [EW-1:0] so_d [2];

	logic [EW-1:0] buf_q [vpc_pkg::BUF_DEPTH];
	logic [1:0] bcnt_q;
	logic brp_q;
	logic bwp_q;
	logic buf_room;
	logic buf_pop;

	logic accept;
	logic free_u;
	logic war;
	int iu;

	function automatic logic elem_ready(input logic [RW-1:0] r,
		input logic [CW-1:0] idx);
		logic hit;
		hit = 1'b0;
		for (int u = 0; u < NU; u++)
			if (wr_v[u] && wr_r[u] == r && wr_i[u] == idx)
				hit = 1'b1;
		return !busy_q[r] || idx < wcnt_q[r] || hit;
	endfunction : elem_ready

	function automatic logic [EW-1:0] elem_data(input logic [RW-1:0] r,
		input logic [CW-1:0] idx);
		logic [EW-1:0] d;
		d = vreg_q[r][idx[vpc_pkg::IDX_W-1:0]];
		for (int u = 0; u < NU; u++)
			if (wr_v[u] && wr_r[u] == r && wr_i[u] == idx)
				d = wr_d[u];
		return d;
	endfunction : elem_data

	function automatic logic mask_bit(input logic [EW-1:0] m,
		input logic [CW-1:0] idx);
		return m[EW-1-int'(idx[vpc_pkg::IDX_W-1:0])];
	endfunction : mask_bit

	function automatic logic reads_two(input vpc_pkg::vpc_op_t op,
		input logic usc);
		return !usc && op != vpc_pkg::OP_LOAD && op != vpc_pkg::OP_STORE;
	endfunction : reads_two

	// setup ops must never start a unit or reserve a register
	function automatic logic is_setup(input vpc_pkg::vpc_op_t op);
		return op == vpc_pkg::OP_SET_VL || op == vpc_pkg::OP_SET_VM;
	endfunction : is_setup

	// result write ports, one per unit
	always_comb
	begin
		for (int u = 0; u < NU; u++)
		begin
			wr_r[u] = dst_q[u];
			wr_i[u] = re_q[u];
		end
		for (int u = 0; u < 2; u++)
		begin
			wr_v[u] = so_v[u];
			wr_d[u] = so_d[u];
		end
		wr_v[2] = mem_rd_ready_o && mem_rd_valid_i;
		wr_d[2] = mem_rd_data_i;
	end

	assign mem_rd_ready_o = act_q[2] && op_q[2] == vpc_pkg::OP_LOAD
		&& re_q[2] < len_q[2];

	// operand fetch and element issue
	always_comb
	begin
		for (int u = 0; u < NU; u++)
		begin
			opb[u] = usc_q[u] ? sc_q[u] : elem_data(s2_q[u], ie_q[u]);
			opa[u] = elem_data(s1_q[u], ie_q[u]);
			if (op_q[u] == vpc_pkg::OP_MERGE)
				opa[u] = mask_bit(vm_q, ie_q[u]) ? opa[u] : opb[u];
			fire[u] = act_q[u] && ie_q[u] < len_q[u]
				&& op_q[u] != vpc_pkg::OP_LOAD
				&& elem_ready(s1_q[u], ie_q[u])
				&& (!reads_two(op_q[u], usc_q[u])
				|| elem_ready(s2_q[u], ie_q[u]));
		end
		fire[2] = fire[2] && buf_room;
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_fu
		vpc_seg_unit #(
			.LAT(g == 0 ? vpc_pkg::ADD_LAT : vpc_pkg::LOGIC_LAT)
		) u_seg (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.in_valid_i(fire[g]),
			.in_fn_i(vpc_pkg::fn_of(op_q[g])),
			.in_a_i(opa[g]),
			.in_b_i(opb[g]),
			.out_valid_o(so_v[g]),
			.out_data_o(so_d[g])
		);
	end

	// issue check
	always_comb
	begin
		iu = vpc_pkg::unit_of(inst_op_i);
		free_u = !act_q[iu];
		war = 1'b0;
		// target must not be a live source
		for (int u = 0; u < NU; u++)
			if (act_q[u] && op_q[u] != vpc_pkg::OP_LOAD
				&& (s1_q[u] == inst_dst_i
				|| (reads_two(op_q[u], usc_q[u])
				&& s2_q[u] == inst_dst_i)))
				war = 1'b1;
		// count and mask writes never wait
		if (is_setup(inst_op_i))
			inst_ready_o = 1'b1;
		else if (inst_op_i == vpc_pkg::OP_STORE)
			inst_ready_o = free_u;
		else
			// hold on unit or target reservation
			inst_ready_o = free_u && !busy_q[inst_dst_i] && !war;
	end

	assign accept = inst_valid_i && inst_ready_o;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			vl_q <= vpc_pkg::VL_RESET;
			vm_q <= vpc_pkg::VM_RESET;
		end
		else if (accept && inst_op_i == vpc_pkg::OP_SET_VL)
			vl_q <= inst_scalar_i > EW'(vpc_pkg::VL_MAX)
				? vpc_pkg::VL_MAX : inst_scalar_i[CW-1:0];
		else if (accept && inst_op_i == vpc_pkg::OP_SET_VM)
			vm_q <= inst_scalar_i;
	end

	// unit sequencing, memory path treated as a unit
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			act_q <= '0;
			usc_q <= '0;
			for (int u = 0; u < NU; u++)
			begin
				op_q[u] <= vpc_pkg::OP_ADD;
				dst_q[u] <= '0;
				s1_q[u] <= '0;
				s2_q[u] <= '0;
				sc_q[u] <= '0;
				len_q[u] <= '0;
				ie_q[u] <= '0;
				re_q[u] <= '0;
			end
		end
		else
			for (int u = 0; u < NU; u++)
			begin
				if (fire[u])
					ie_q[u] <= ie_q[u] + 1'b1;
				if (wr_v[u] || (u == 2 && fire[u]))
				begin
					re_q[u] <= re_q[u] + 1'b1;
					if (re_q[u] + 1'b1 == len_q[u])
						act_q[u] <= 1'b0;
				end
				if (accept && iu == u && vl_q != '0
					&& !is_setup(inst_op_i))
				begin
					act_q[u] <= 1'b1;
					op_q[u] <= inst_op_i;
					dst_q[u] <= inst_dst_i;
					s1_q[u] <= first_operand_array_i;
					s2_q[u] <= second_operand_array_i;
					sc_q[u] <= inst_scalar_i;
					usc_q[u] <= inst_use_scalar_i;
					len_q[u] <= vl_q;
					ie_q[u] <= '0;
					re_q[u] <= '0;
				end
			end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			busy_q <= '0;
			for (int r = 0; r < NREG; r++)
				wcnt_q[r] <= '0;
		end
		else
		begin
			for (int u = 0; u < NU; u++)
				if (wr_v[u])
				begin
					wcnt_q[wr_r[u]] <= wr_i[u] + 1'b1;
					if (wr_i[u] + 1'b1 == len_q[u])
						busy_q[wr_r[u]] <= 1'b0;
				end
			if (accept && vl_q != '0 && inst_op_i != vpc_pkg::OP_STORE
				&& !is_setup(inst_op_i))
			begin
				busy_q[inst_dst_i] <= 1'b1;
				wcnt_q[inst_dst_i] <= '0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		for (int u = 0; u < NU; u++)
			if (wr_v[u])
				vreg_q[wr_r[u]][wr_i[u][vpc_pkg::IDX_W-1:0]] <= wr_d[u];
	end

	// two-entry store buffer; a memory stall backs up into element issue
	assign buf_room = bcnt_q < 2'(vpc_pkg::BUF_DEPTH);
	assign buf_pop = mem_wr_valid_o && mem_wr_ready_i;
	assign mem_wr_valid_o = bcnt_q != 2'h0;
	assign mem_wr_data_o = buf_q[brp_q];

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			bcnt_q <= 2'h0;
			brp_q <= 1'b0;
			bwp_q <= 1'b0;
			for (int i = 0; i < vpc_pkg::BUF_DEPTH; i++)
				buf_q[i] <= '0;
		end
		else
		begin
			if (fire[2])
			begin
				buf_q[bwp_q] <= opa[2];
				bwp_q <= !bwp_q;
			end
			if (buf_pop)
				brp_q <= !brp_q;
			bcnt_q <= bcnt_q + 2'(fire[2]) - 2'(buf_pop);
		end
	end

	assign element_count_register_o = vl_q;
	assign element_mask_register_o = vm_q;
	assign unit_busy_o = act_q;
	assign reg_reserved_o = busy_q;
endmodule : vpc_chain_ctrl
`default_nettype wire

// File: verilog/vpc_seg_unit.sv
`default_nettype none
module vpc_seg_unit #(
	parameter int LAT = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// operand pair in
	input wire logic in_valid_i,
	input wire vpc_pkg::vpc_fn_t in_fn_i,
	input wire logic [vpc_pkg::ELEM_W-1:0] in_a_i,
	input wire logic [vpc_pkg::ELEM_W-1:0] in_b_i,
	// result out
	output logic out_valid_o,
	output logic [vpc_pkg::ELEM_W-1:0] out_data_o
);
	logic [LAT-1:0] v_q;
	logic [vpc_pkg::ELEM_W-1:0] d_q [LAT];
	logic [vpc_pkg::ELEM_W-1:0] first_d;

	if (LAT < 1)
		$error("segment count must be at least one");

	always_comb
	begin
		unique case (in_fn_i)
			vpc_pkg::FN_ADD: first_d = in_a_i + in_b_i;
			vpc_pkg::FN_SUB: first_d = in_a_i - in_b_i;
			vpc_pkg::FN_AND: first_d = in_a_i & in_b_i;
			vpc_pkg::FN_PASS: first_d = in_a_i;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			v_q <= '0;
		else
		begin
			v_q[0] <= in_valid_i;
			for (int s = 1; s < LAT; s++)
				v_q[s] <= v_q[s-1];
		end
	end

	// data needs no reset, valid qualifies it
	always_ff @(posedge clk_i)
	begin
		d_q[0] <= first_d;
		for (int s = 1; s < LAT; s++)
			d_q[s] <= d_q[s-1];
	end

	assign out_valid_o = v_q[LAT-1];
	assign out_data_o = d_q[LAT-1];
endmodule : vpc_seg_unit
`default_nettype wire
